//--- cits_defines.svh
`ifndef CITS_DEFINES_SVH
`define CITS_DEFINES_SVH

// control and status register byte addresses
`define CITS_OFS_CTRL 4'h0
`define CITS_OFS_SAREA 4'h4
`define CITS_OFS_STATUS 4'h8
`define CITS_OFS_IDENT 4'hc

// control register fields
`define CITS_CTRL_SEG 0
`define CITS_CTRL_SYS 1
`define CITS_CTRL_VIE 2
`define CITS_CTRL_NVIE 3
`define CITS_CTRL_XPU 4

// flag/control word bits
`define CITS_FLAG_SEG 15
`define CITS_FLAG_SYS 14
`define CITS_FLAG_XPU 13
`define CITS_FLAG_VIE 12
`define CITS_FLAG_NVIE 11

// cause codes reported in status
`define CITS_CAUSE_PRIV 3'h1
`define CITS_CAUSE_SC 3'h2
`define CITS_CAUSE_EXT 3'h3
`define CITS_CAUSE_NMI 3'h4
`define CITS_CAUSE_SEGT 3'h5
`define CITS_CAUSE_VI 3'h6
`define CITS_CAUSE_NVI 3'h7

`define CITS_RST_CTRL 5'h03
`define CITS_RST_SAREA 16'h0000
`define CITS_RST_SP 16'h0000

`endif

//--- cits_pkg.sv
package cits_pkg;

	typedef enum logic [2:0] {
		CITS_SRC_NONE,
		CITS_SRC_INT,
		CITS_SRC_NMI,
		CITS_SRC_SEGT,
		CITS_SRC_VI,
		CITS_SRC_NVI
	} cits_src_t;

	// one word transaction toward system memory
	typedef struct packed {
		logic wr;
		logic [6:0] seg;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cits_mem_req_t;

	// instruction boundary report from the core
	typedef struct packed {
		logic boundary;
		logic priv;
		logic syscall;
		logic ext;
		logic [15:0] first_word;
		logic [15:0] pc_off;
		logic [6:0] pc_seg;
		logic [15:0] flags;
	} cits_core_t;

endpackage

//--- cits_seq.sv
// Function
// RL1: accept non-maskable, vectored and non-vectored interrupts
// RL2: mask vectored and non-vectored; non-maskable always
// RL3: segmentation trap external, others generated internally
// RL4: trap on privileged, system call, extended instruction
// RL5: priority internal, nmi, segment, vectored, non-vectored
// RL6: push program counter, flag word, 16-bit identifier
// RL7: internal trap identifier is first instruction word
// RL8: external causes supply vector during acknowledge
// RL9: load new status from pointer-addressed status area
// RL10: nonsegmented status group is two words
// RL11: segmented group: two-word counter, flags, reserved
// RL12: seven bits of first word select segment
// RL13: second counter word holds 16-bit offset
// RL14: separate system and normal stack pointers
// RL15: segmented stack pointer pair is registers 14/15
// RL16: nonsegmented stack pointer is register 15
// RL17: flag word same except segment-enable bit
// RL18: system and normal mode; privilege drives trap
// RL19: sample requests only at instruction boundaries
// RL20: predecrement stack pointer before each word written
`timescale 1ns/1ns
`include "cits_defines.svh"

module cits_seq
	import cits_pkg::*;
#(
	parameter int SEG_BITS = 7
) (
	input wire logic clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// requests from peripherals and memory manager
	input wire logic nmi_req,
	input wire logic vi_req,
	input wire logic nvi_req,
	input wire logic segt_req,
	// core boundary report
	input wire cits_core_t core,
	// memory side
	output cits_mem_req_t mem_req,
	output logic mem_valid,
	input wire logic mem_ready,
	input wire logic [15:0] mem_rdata,
	// acknowledge cycle
	output logic ack_r,
	output cits_src_t ack_src_r,
	input wire logic ack_valid,
	input wire logic [15:0] ack_vector,
	// new status to the core
	output logic load_valid_r,
	output logic [15:0] new_flags_r,
	output logic [6:0] new_pc_seg_r,
	output logic [15:0] new_pc_off_r,
	output logic busy_r
);

	// only the seven-bit segment number of the status group is served
	if (SEG_BITS != 7) begin : g_seg_check
		$error("segment number must be seven bits");
	end

	typedef enum logic [3:0] {
		ST_IDLE, ST_ACK, ST_PUSH, ST_FETCH, ST_DONE
	} cits_state_t;

	function automatic cits_src_t pick(input logic it, input logic n, input logic s,
		input logic v, input logic nv);
		if (it) pick = CITS_SRC_INT; // RL5
		else if (n) pick = CITS_SRC_NMI;
		else if (s) pick = CITS_SRC_SEGT;
		else if (v) pick = CITS_SRC_VI;
		else if (nv) pick = CITS_SRC_NVI;
		else pick = CITS_SRC_NONE;
	endfunction

	// acknowledged sources map one to one onto reported causes
	function automatic logic [2:0] ext_cause(input cits_src_t s);
		case (s)
		CITS_SRC_NMI: ext_cause = `CITS_CAUSE_NMI;
		CITS_SRC_SEGT: ext_cause = `CITS_CAUSE_SEGT;
		CITS_SRC_VI: ext_cause = `CITS_CAUSE_VI;
		default: ext_cause = `CITS_CAUSE_NVI;
		endcase
	endfunction

	// push order after predecrement: offset, segment (segmented only), flags, identifier
	function automatic logic [15:0] push_word(input logic seg, input logic [1:0] i,
		input logic [15:0] off, input logic [6:0] sg, input logic [15:0] fl,
		input logic [15:0] id);
		if (seg) begin
			case (i)
			2'h0: push_word = off;
			2'h1: push_word = {1'b1, sg, 8'h00};
			2'h2: push_word = fl;
			default: push_word = id;
			endcase
		end else begin
			case (i)
			2'h0: push_word = off;
			2'h1: push_word = fl;
			default: push_word = id;
			endcase
		end
	endfunction

	cits_state_t state_r;
	logic [4:0] ctrl_r;
	logic [15:0] sarea_ptr_r;
	// stack pointers: only the system one is used for saves
	logic [15:0] sys_sp_r;
	logic [15:0] nrm_sp_r;
	logic [6:0] sys_seg_r;
	logic [15:0] ident_r;
	logic [2:0] cause_r;
	logic [15:0] sv_flags_r;
	logic [15:0] sv_off_r;
	logic [6:0] sv_seg_r;
	logic [1:0] idx_r;
	logic nmi_pend_r;
	logic [31:0] rdata_nxt;
	logic ack_done_r;
	logic seg_mode;
	logic int_trap;
	logic [2:0] int_cause;
	logic [1:0] last_idx;
	cits_src_t src;
	cits_mem_req_t mem_req_nxt;
	logic mem_valid_nxt;

	assign seg_mode = ctrl_r[`CITS_CTRL_SEG];
	// privileged use only outside system mode, extended only without coprocessor
	assign int_trap = (core.priv & ~ctrl_r[`CITS_CTRL_SYS]) | core.syscall
		| (core.ext & ~ctrl_r[`CITS_CTRL_XPU]); // RL4 RL18 RL3
	assign int_cause = core.syscall ? `CITS_CAUSE_SC :
		(core.ext & ~ctrl_r[`CITS_CTRL_XPU]) ? `CITS_CAUSE_EXT : `CITS_CAUSE_PRIV;
	// three-word group pushed segmented, two otherwise; push adds the identifier
	assign last_idx = seg_mode ? 2'h3 : 2'h2; // RL10 RL11
	assign src = pick(int_trap, nmi_pend_r, segt_req,
		vi_req & ctrl_r[`CITS_CTRL_VIE], nvi_req & ctrl_r[`CITS_CTRL_NVIE]); // RL1 RL2

	// edge-triggered nmi held until serviced; new edge wins over the clear
	logic nmi_d_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			nmi_d_r <= 1'b0;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_d_r <= nmi_req;
			if (nmi_req & ~nmi_d_r)
				nmi_pend_r <= 1'b1; // RL1
			else if (state_r == ST_ACK && ack_src_r == CITS_SRC_NMI && ack_done_r)
				nmi_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			ack_r <= 1'b0;
			ack_src_r <= CITS_SRC_NONE;
			ack_done_r <= 1'b0;
			ident_r <= 16'h0000;
			cause_r <= 3'h0;
			sv_flags_r <= 16'h0000;
			sv_off_r <= 16'h0000;
			sv_seg_r <= 7'h00;
			idx_r <= 2'h0;
			load_valid_r <= 1'b0;
			new_flags_r <= 16'h0000;
			new_pc_seg_r <= 7'h00;
			new_pc_off_r <= 16'h0000;
			busy_r <= 1'b0;
			sys_sp_r <= `CITS_RST_SP;
		end else begin
			load_valid_r <= 1'b0;
			ack_done_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (core.boundary && src != CITS_SRC_NONE) begin // RL19
					busy_r <= 1'b1;
					sv_flags_r <= core.flags;
					sv_off_r <= core.pc_off;
					sv_seg_r <= core.pc_seg;
					ack_src_r <= src;
					idx_r <= 2'h0;
					if (src == CITS_SRC_INT) begin
						ident_r <= core.first_word; // RL7
						cause_r <= int_cause;
						state_r <= ST_PUSH;
					end else begin
						ack_r <= 1'b1; // RL8
						state_r <= ST_ACK;
						cause_r <= ext_cause(src);
					end
				end
			end
			ST_ACK: begin
				if (ack_valid) begin
					ident_r <= ack_vector; // RL8
					ack_r <= 1'b0;
					ack_done_r <= 1'b1;
				end
				// one spare cycle lets the nmi clear see the finished acknowledge
				if (ack_done_r)
					state_r <= ST_PUSH;
			end
			ST_PUSH: begin
				if (mem_ready) begin
					// stack pointer moves only on an accepted word
					sys_sp_r <= sys_sp_r - 16'h0002; // RL20
					idx_r <= idx_r + 2'h1;
					if (idx_r == last_idx) begin
						idx_r <= 2'h0;
						state_r <= ST_FETCH;
					end
				end
			end
			ST_FETCH: begin
				if (mem_ready) begin
					idx_r <= idx_r + 2'h1;
					if (seg_mode) begin // RL11
						// word 0 of the four-word group is reserved and skipped
						case (idx_r)
						2'h1: new_flags_r <= mem_rdata; // RL17
						2'h2: new_pc_seg_r <= mem_rdata[14:8]; // RL12
						2'h3: new_pc_off_r <= mem_rdata; // RL13
						default: ;
						endcase
						if (idx_r == 2'h3)
							state_r <= ST_DONE;
					end else begin // RL10
						if (idx_r == 2'h0)
							// no segment bit in the two-word layout
							new_flags_r <= mem_rdata & ~(16'h0001 << `CITS_FLAG_SEG); // RL17
						else
							new_pc_off_r <= mem_rdata;
						new_pc_seg_r <= 7'h00;
						if (idx_r == 2'h1)
							state_r <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				// one-cycle pulse raised at this edge; the core takes the new status at the next edge
				load_valid_r <= 1'b1;
				busy_r <= 1'b0;
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		mem_valid_nxt = 1'b0;
		mem_req_nxt = '0;
		if (state_r == ST_PUSH) begin // RL6 RL14
			mem_valid_nxt = 1'b1;
			mem_req_nxt.wr = 1'b1;
			mem_req_nxt.seg = seg_mode ? sys_seg_r : 7'h00; // RL15 RL16
			mem_req_nxt.addr = sys_sp_r - 16'h0002;
			mem_req_nxt.wdata = push_word(seg_mode, idx_r, sv_off_r, sv_seg_r, sv_flags_r,
				ident_r);
		end else if (state_r == ST_FETCH) begin // RL9
			mem_valid_nxt = 1'b1;
			mem_req_nxt.addr = sarea_ptr_r + {13'h0000, idx_r, 1'b0};
		end
	end

	// registered request; a one-cycle gap after each accepted word keeps
	// the request of the old index from being offered a second time
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_valid <= 1'b0;
			mem_req <= '0;
		end else begin
			mem_valid <= mem_valid_nxt & ~(mem_valid & mem_ready);
			mem_req <= mem_req_nxt;
		end
	end

	// bus slave: reads answered one cycle later, writes at once
	logic rd_pend_r;
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (avs_address)
		`CITS_OFS_CTRL: rdata_nxt = {27'h0, ctrl_r};
		`CITS_OFS_SAREA: rdata_nxt = {16'h0, sarea_ptr_r};
		// status segment field reads back where it is written
		`CITS_OFS_STATUS: rdata_nxt = {12'h000, busy_r, cause_r, 1'b0, sys_seg_r, 5'h00,
			ctrl_r[`CITS_CTRL_SYS], nmi_pend_r, seg_mode};
		`CITS_OFS_IDENT: rdata_nxt = {sys_sp_r, ident_r};
		default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// combinational: the bus needs the stall in the cycle of the request
	assign avs_waitrequest = avs_read & ~rd_pend_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_pend_r <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			rd_pend_r <= avs_read & ~rd_pend_r;
			if (avs_read & ~rd_pend_r)
				avs_readdata <= rdata_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r <= `CITS_RST_CTRL;
			sarea_ptr_r <= `CITS_RST_SAREA;
			sys_seg_r <= 7'h00;
			nrm_sp_r <= `CITS_RST_SP;
		end else if (avs_write) begin
			case (avs_address)
			`CITS_OFS_CTRL: ctrl_r <= avs_writedata[4:0];
			`CITS_OFS_SAREA: sarea_ptr_r <= avs_writedata[15:0];
			`CITS_OFS_STATUS: sys_seg_r <= avs_writedata[14:8];
			`CITS_OFS_IDENT: nrm_sp_r <= avs_writedata[31:16]; // RL14
			default: ;
			endcase
		// a bus write in the same cycle wins over the loaded flags
		end else if (state_r == ST_DONE) begin
			ctrl_r[`CITS_CTRL_SYS] <= new_flags_r[`CITS_FLAG_SYS]; // RL18
			ctrl_r[`CITS_CTRL_VIE] <= new_flags_r[`CITS_FLAG_VIE];
			ctrl_r[`CITS_CTRL_NVIE] <= new_flags_r[`CITS_FLAG_NVIE];
			ctrl_r[`CITS_CTRL_XPU] <= new_flags_r[`CITS_FLAG_XPU];
		end
	end

endmodule

//--- cits_seq_monitor.sv
`timescale 1ns/1ns
module cits_seq_monitor
	import cits_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire cits_core_t core,
	input wire cits_mem_req_t mem_req,
	input wire logic mem_valid,
	input wire logic mem_ready,
	input wire logic ack_r,
	input wire logic ack_valid,
	input wire logic load_valid_r,
	input wire logic busy_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer wrong");
	wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	ack_hold_a: assert property (ack_r && !ack_valid |=> ack_r)
		else $error("ack dropped early");
	mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
		else $error("memory request moved");
	sp_dec_a: assert property (mem_valid && mem_ready && mem_req.wr
		##2 mem_valid && mem_req.wr |-> mem_req.addr == $past(mem_req.addr, 2) - 16'h0002)
		else $error("push address wrong");
	load_pulse_a: assert property (load_valid_r |=> !load_valid_r)
		else $error("load pulse too long");
	int_trap_a: assert property (core.boundary && core.syscall && !busy_r |=> busy_r && !ack_r)
		else $error("internal trap wrong");
	bound_only_a: assert property (!core.boundary && !busy_r |=> !busy_r)
		else $error("start off boundary");
	ack_c: cover property (ack_r && ack_valid);
	load_c: cover property (load_valid_r);
	rd_c: cover property (avs_read && !avs_waitrequest);
endmodule

//--- cits_seq_partner.sv
`timescale 1ns/1ns
module cits_seq_partner
	import cits_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [1:0] slow,
	input wire cits_mem_req_t mem_req,
	input wire logic mem_valid,
	output logic mem_ready,
	output logic [15:0] mem_rdata,
	input wire logic ack_r,
	input wire cits_src_t ack_src_r,
	output logic ack_valid,
	output logic [15:0] ack_vector
);
	logic [15:0] mem [0:255];
	logic [1:0] wait_r;
	// idle lines toggle so a stale value never passes for an answer
	always @(posedge clk) begin
		if (srst) begin
			wait_r <= 2'h0;
			mem_ready <= 1'b0;
			mem_rdata <= 16'h0;
			ack_valid <= 1'b0;
			ack_vector <= 16'h0;
		end else begin
			if (mem_valid && !mem_ready && wait_r == slow) begin
				mem_ready <= 1'b1;
				wait_r <= 2'h0;
				if (mem_req.wr)
					mem[mem_req.addr[8:1]] <= mem_req.wdata;
				mem_rdata <= mem_req.wr ? ~mem_rdata : mem[mem_req.addr[8:1]];
			end else begin
				mem_ready <= 1'b0;
				mem_rdata <= ~mem_rdata;
				if (mem_valid && !mem_ready)
					wait_r <= wait_r + 2'h1;
			end
			if (ack_r && !ack_valid) begin
				ack_valid <= 1'b1;
				ack_vector <= {13'h0020, ack_src_r};
			end else begin
				ack_valid <= 1'b0;
				ack_vector <= ~ack_vector;
			end
		end
	end
endmodule

//--- cits_seq_tb.sv
`timescale 1ns/1ns
module cits_seq_tb
	import cits_pkg::*;
;
	logic clk, srst, avs_read, avs_write, avs_waitrequest, nmi_req, vi_req, nvi_req, segt_req;
	logic mem_valid, mem_ready, ack_r, ack_valid, load_valid_r, busy_r;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] mem_rdata, ack_vector, new_flags_r, new_pc_off_r;
	logic [6:0] new_pc_seg_r;
	logic [1:0] slow;
	cits_core_t core;
	cits_mem_req_t mem_req;
	cits_src_t ack_src_r, s;
	int mismatches, n_compared;
	cits_seq cits_seq_inst (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .nmi_req, .vi_req, .nvi_req, .segt_req, .core,
		.mem_req, .mem_valid, .mem_ready, .mem_rdata, .ack_r, .ack_src_r, .ack_valid,
		.ack_vector, .load_valid_r, .new_flags_r, .new_pc_seg_r, .new_pc_off_r, .busy_r);
	cits_seq_partner cits_seq_partner_inst (.clk, .srst, .slow, .mem_req, .mem_valid,
		.mem_ready, .mem_rdata, .ack_r, .ack_src_r, .ack_valid, .ack_vector);
	function automatic logic [15:0] m(input int i);
		return cits_seq_partner_inst.mem[i];
	endfunction
	task automatic test_done;
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic expire;
		mismatches++;
		test_done;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 20)
			expire;
	endtask
	task automatic step(input logic [2:0] k);
		@(posedge clk);
		core.boundary <= 1'b1;
		{core.priv, core.syscall, core.ext} <= k;
		@(posedge clk);
		core.boundary <= 1'b0;
		{core.priv, core.syscall, core.ext} <= 3'h0;
	endtask
	// samples mid-cycle so registered outputs have settled
	task automatic run;
		int i;
		s = CITS_SRC_NONE;
		for (i = 0; i < 400; i++) begin
			@(negedge clk);
			if (ack_r === 1'b1)
				s = ack_src_r;
			if (load_valid_r === 1'b1)
				break;
		end
		if (i == 400)
			expire;
	endtask
	task automatic t_regs;
		bus(1'b0, 4'h0, 32'h0, q);
		chk("ctrl", 32'h3, q);
		bus(1'b0, 4'h2, 32'h0, q);
		chk("unmapped", 32'h0, q);
		bus(1'b1, 4'h4, 32'h40, q);
		bus(1'b0, 4'h4, 32'h0, q);
		chk("sarea", 32'h40, q);
	endtask
	task automatic t_trap;
		@(posedge clk);
		core.pc_off <= 16'h1234;
		core.pc_seg <= 7'h05;
		core.flags <= 16'hc000;
		core.first_word <= 16'h7f00;
		nmi_req <= 1'b1;
		step(3'b010);
		run;
		chk("trap src", CITS_SRC_NONE, s);
		chk("offset", 16'h1234, m(255));
		chk("seg word", 16'h8500, m(254));
		chk("flags", 16'hc000, m(253));
		chk("ident", 16'h7f00, m(252));
		chk("new flags", 16'hc000, new_flags_r);
		chk("new seg", 7'h2a, new_pc_seg_r);
		chk("new off", 16'h0246, new_pc_off_r);
	endtask
	task automatic t_nmi;
		@(posedge clk);
		vi_req <= 1'b1;
		step(3'b000);
		run;
		chk("nmi src", CITS_SRC_NMI, s);
		chk("nmi ident", 16'h0102, m(248));
		step(3'b000);
		repeat (3) @(negedge clk);
		chk("vi masked", 1'b0, busy_r);
		step(3'b001);
		run;
		chk("ext ident", 16'h7f00, m(244));
	endtask
	task automatic t_nonseg;
		bus(1'b1, 4'h0, 32'he, q);
		@(posedge clk);
		segt_req <= 1'b1;
		nvi_req <= 1'b1;
		slow <= 2'h2;
		step(3'b000);
		run;
		chk("segt src", CITS_SRC_SEGT, s);
		chk("pc", 16'h1234, m(243));
		chk("ns flags", 16'hc000, m(242));
		chk("segt ident", 16'h0103, m(241));
		chk("ns new flags", 16'h5800, new_flags_r);
		chk("ns new pc", 16'hc000, new_pc_off_r);
		@(posedge clk);
		segt_req <= 1'b0;
		step(3'b000);
		run;
		chk("vi src", CITS_SRC_VI, s);
		@(posedge clk);
		vi_req <= 1'b0;
		step(3'b000);
		run;
		chk("nvi src", CITS_SRC_NVI, s);
		bus(1'b0, 4'hc, 32'h0, q);
		chk("sp ident", 32'hffd6_0105, q);
		bus(1'b0, 4'h8, 32'h0, q);
		chk("status", 32'h0007_0004, q);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		srst = 1'b1;
		{avs_read, avs_write, nmi_req, vi_req, nvi_req, segt_req} = '0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		slow = 2'h0;
		core = '0;
		mismatches = 0;
		n_compared = 0;
		cits_seq_partner_inst.mem[32] = 16'h5800;
		cits_seq_partner_inst.mem[33] = 16'hc000;
		cits_seq_partner_inst.mem[34] = 16'h2a00;
		cits_seq_partner_inst.mem[35] = 16'h0246;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_regs;
		t_trap;
		t_nmi;
		t_nonseg;
		test_done;
	end
endmodule
bind cits_seq cits_seq_monitor cits_seq_monitor_inst (.clk, .srst, .avs_read, .avs_write,
	.avs_waitrequest, .core, .mem_req, .mem_valid, .mem_ready, .ack_r, .ack_valid,
	.load_valid_r, .busy_r);
